// ### rtl/hpw_wake_ctrl.sv
// Purpose: wake, playback and shutdown control of the output stage
// Assumes: apb master on core_clk; rst synchronous, active high
// Notes: long counts are parameters so simulation may shorten them
`timescale 1ns/10ps
`include "hpw_params.svh"
module hpw_wake_ctrl #(
    parameter int STARTUP_CYC = `HPW_STARTUP_CYC,
    parameter int TO_STEP_CYC = `HPW_TO_STEP_CYC,
    parameter int SAMPLE_CYC  = `HPW_SAMPLE_CYC
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire hpw_pkg::hpw_apb_req_t apb_req,
    output hpw_pkg::hpw_apb_rsp_t      apb_rsp,
    output logic                       boost_en,
    output logic                       amp_en,
    output logic                 [7:0] dac_code,
    output logic                       playback_start,
    output logic                 [1:0] playback_mode
);
    import hpw_pkg::*;

    // ****************************************************************
    // limits
    // ****************************************************************
    localparam logic [23:0] STARTUP_LIM = 24'(STARTUP_CYC - 1);
    localparam logic [23:0] SAMPLE_LIM  = 24'(SAMPLE_CYC - 1);
    localparam logic [23:0] TO_LIM0     = 24'(TO_STEP_CYC - 1);
    localparam logic [23:0] TO_LIM1     = 24'(TO_STEP_CYC * 2 - 1);
    localparam logic [23:0] TO_LIM2     = 24'(TO_STEP_CYC * 3 - 1);
    localparam logic [23:0] TO_LIM3     = 24'(TO_STEP_CYC * 4 - 1);

    // ****************************************************************
    // state
    // ****************************************************************
    hpw_core_t   r;
    hpw_core_t   n;
    logic        fifo_push;
    logic        fifo_pop;
    logic        fifo_flush;
    logic [7:0]  fifo_data;
    logic        fifo_full;
    logic        fifo_empty;
    logic [7:0]  ramp_step;
    logic        stage_on;
    logic        stage_need;
    logic        go_wr;
    logic        tick;
    logic        accepting;
    logic        setup_done;
    logic        done;
    logic        soft_rst;
    logic        hit_ctrl;
    logic        hit_fifo;
    logic        hit_stat;
    logic [23:0] to_lim;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;

    function automatic hpw_core_t core_reset();
        hpw_core_t v;
        v          = '0;
        v.st       = ST_STANDBY;
        v.standby  = 1'b1;
        v.dac      = `HPW_MID_SCALE;
        return v;
    endfunction

    // ****************************************************************
    // sub blocks
    // ****************************************************************
    hpw_fifo u_fifo (
        .core_clk (core_clk),
        .rst      (rst),
        .flush    (fifo_flush),
        .push     (fifo_push),
        .wdata    (apb_req.pwdata[7:0]),
        .pop      (fifo_pop),
        .rdata    (fifo_data),
        .full     (fifo_full),
        .empty    (fifo_empty)
    );

    hpw_ramp u_ramp (
        .code (r.dac),
        .step (ramp_step)
    );

    // ****************************************************************
    // register words
    // ****************************************************************
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`HPW_CTRL_STANDBY] = r.standby;
        ctrl_word[`HPW_CTRL_FORCE] = r.force_on;
        ctrl_word[`HPW_CTRL_GO] = r.go;
        ctrl_word[`HPW_CTRL_TO +: 2] = r.to_sel;
        ctrl_word[`HPW_CTRL_MODE +: 2] = r.mode;
        stat_word = 32'h0000_0000;
        stat_word[`HPW_ST_FULL] = fifo_full;
        stat_word[`HPW_ST_EMPTY] = fifo_empty;
        stat_word[`HPW_ST_UP] = r.stage_up;
        stat_word[`HPW_ST_ON] = r.boost_en;
        stat_word[`HPW_ST_NAK] = r.nak;
        stat_word[`HPW_ST_STATE +: 3] = r.st;
        stat_word[`HPW_ST_DAC +: 8] = r.dac;
    end

    always_comb begin
        hit_ctrl = 1'b0;
        hit_fifo = 1'b0;
        hit_stat = 1'b0;
        if (apb_req.paddr == `HPW_OFS_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (apb_req.paddr == `HPW_OFS_FIFO) begin
            hit_fifo = 1'b1;
        end else if (apb_req.paddr == `HPW_OFS_STATUS) begin
            hit_stat = 1'b1;
        end
    end

    always_comb begin
        case (r.to_sel)
            2'h0:    to_lim = TO_LIM0;
            2'h1:    to_lim = TO_LIM1;
            2'h2:    to_lim = TO_LIM2;
            default: to_lim = TO_LIM3;
        endcase
    end

    // ****************************************************************
    // output stage demand
    // ****************************************************************
    always_comb begin
        case (r.st)
            ST_WAKE: stage_need = 1'b1;
            ST_PLAY: stage_need = 1'b1;
            ST_HOLD: stage_need = 1'b1;
            ST_RAMP: stage_need = 1'b1;
            default: stage_need = 1'b0;
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        n = r;
        n.start = 1'b0;
        fifo_push = 1'b0;
        fifo_pop = 1'b0;
        fifo_flush = 1'b0;
        soft_rst = 1'b0;
        go_wr = 1'b0;
        setup_done = apb_req.psel & apb_req.penable & ~r.rsp.pready;
        done = apb_req.psel & apb_req.penable & r.rsp.pready;
        // fifo writes refused in standby and while ramping down
        accepting = ~r.standby & (r.st != ST_STANDBY)
                  & (r.st != ST_RAMP);

        // ************************************************************
        // bus answer, one cycle into the access phase
        // ************************************************************
        n.rsp.pready = setup_done;
        n.rsp.prdata = 32'h0000_0000;
        n.rsp.pslverr = 1'b0;
        if (setup_done) begin
            if (hit_ctrl) begin
                n.rsp.prdata = ctrl_word;
            end else if (hit_fifo) begin
                n.rsp.pslverr = apb_req.pwrite & accepting & fifo_full;
            end else if (hit_stat) begin
                n.rsp.prdata = stat_word;
            end else begin
                n.rsp.pslverr = 1'b1;
            end
        end

        // ************************************************************
        // register writes
        // ************************************************************
        if (done & apb_req.pwrite) begin
            if (hit_ctrl) begin
                n.standby = apb_req.pwdata[`HPW_CTRL_STANDBY];
                n.force_on = apb_req.pwdata[`HPW_CTRL_FORCE];
                n.to_sel = apb_req.pwdata[`HPW_CTRL_TO +: 2];
                n.mode = apb_req.pwdata[`HPW_CTRL_MODE +: 2];
                // go counts only in memory or synthesis mode
                if (apb_req.pwdata[`HPW_CTRL_GO]
                    && apb_req.pwdata[`HPW_CTRL_MODE +: 2] != 2'h0) begin
                    go_wr = 1'b1;
                end
                soft_rst = apb_req.pwdata[`HPW_CTRL_RST];
            end else if (hit_fifo) begin
                // refusal decided with the answer, so it matches pslverr
                fifo_push = accepting & ~fifo_full
                          & ~r.rsp.pslverr;
            end else if (hit_stat) begin
                // write one clears the refused-byte flag
                if (apb_req.pwdata[`HPW_ST_NAK]) begin
                    n.nak = 1'b0;
                end
            end
        end
        if (done & apb_req.pwrite & hit_fifo & r.rsp.pslverr) begin
            n.nak = 1'b1;
        end

        // ************************************************************
        // output stage warm-up
        // ************************************************************
        stage_on = (stage_need | r.force_on)
                 & ~r.standby;
        if (!stage_on) begin
            n.warm_cnt = 24'h00_0000;
            n.stage_up = 1'b0;
        end else if (!r.stage_up) begin
            if (r.warm_cnt == STARTUP_LIM) begin
                n.stage_up = 1'b1;
            end else begin
                n.warm_cnt = r.warm_cnt + 24'h00_0001;
            end
        end
        n.boost_en = stage_on;
        n.amp_en = stage_on;

        // ************************************************************
        // sample clock
        // ************************************************************
        tick = (r.tick_cnt == SAMPLE_LIM);
        n.tick_cnt = tick ? 24'h00_0000 : r.tick_cnt + 24'h00_0001;

        // ************************************************************
        // playback states
        // ************************************************************
        case (r.st)
            ST_STANDBY: begin
                n.dac = `HPW_MID_SCALE;
                n.go = 1'b0;
                fifo_flush = 1'b1;
                if (!r.standby) begin
                    n.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                n.dac = `HPW_MID_SCALE;
                if (!fifo_empty || r.go) begin
                    n.st = ST_WAKE;
                end
            end
            ST_WAKE: begin
                // samples wait and dac rests at mid-scale
                n.dac = `HPW_MID_SCALE;
                n.tick_cnt = SAMPLE_LIM;
                if (r.stage_up) begin
                    n.st = ST_PLAY;
                    n.start = r.go;
                    n.go = 1'b0;
                end
            end
            ST_PLAY: begin
                if (tick) begin
                    if (!fifo_empty) begin
                        fifo_pop = 1'b1;
                        n.dac = fifo_data;
                    end else begin
                        n.st = ST_HOLD;
                        n.idle_cnt = 24'h00_0000;
                    end
                end
            end
            ST_HOLD: begin
                if (r.go) begin
                    n.start = 1'b1;
                    n.go = 1'b0;
                    n.idle_cnt = 24'h00_0000;
                end else if (tick && !fifo_empty) begin
                    fifo_pop = 1'b1;
                    n.dac = fifo_data;
                    n.st = ST_PLAY;
                end else if (r.idle_cnt == to_lim) begin
                    if (r.dac != `HPW_MID_SCALE) begin
                        n.st = ST_RAMP;
                    end else begin
                        n.st = ST_IDLE;
                    end
                end else begin
                    n.idle_cnt = r.idle_cnt + 24'h00_0001;
                end
            end
            ST_RAMP: begin
                fifo_flush = 1'b1;
                if (tick) begin
                    n.dac = ramp_step;
                    if (ramp_step == `HPW_MID_SCALE) begin
                        n.st = ST_IDLE;
                    end
                end
            end
            default: begin
                n.st = ST_STANDBY;
            end
        endcase

        // ************************************************************
        // overrides
        // ************************************************************
        // a go written while the old one is used stays pending
        if (go_wr && !n.standby) begin
            n.go = 1'b1;
        end

        // standby overrides every other mode
        if (r.standby && r.st != ST_STANDBY) begin
            n.st = ST_STANDBY;
            n.start = 1'b0;
            n.dac = `HPW_MID_SCALE;
            n.go = 1'b0;
            fifo_flush = 1'b1;
        end

        // software reset keeps the bus answer of this access
        if (soft_rst) begin
            n = core_reset();
            n.rsp = r.rsp;
            n.rsp.pready = 1'b0;
            fifo_flush = 1'b1;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            r <= core_reset();
        end else begin
            r <= n;
        end
    end

    assign apb_rsp        = r.rsp;
    assign boost_en       = r.boost_en;
    assign amp_en         = r.amp_en;
    assign dac_code       = r.dac;
    assign playback_start = r.start;
    assign playback_mode  = r.mode;
endmodule

// ### rtl/hpw_params.svh
// Purpose: constants of the haptic playback wake control
// Assumes: core_clk at 125 MHz
// Notes: times in their own unit, cycle counts derived from them
`ifndef HPW_PARAMS_SVH
`define HPW_PARAMS_SVH
`define HPW_CLK_KHZ 125000
`define HPW_STARTUP_MS 2
`define HPW_STARTUP_CYC (`HPW_STARTUP_MS * `HPW_CLK_KHZ)
`define HPW_TO_STEP_MS 5
`define HPW_TO_STEP_CYC (`HPW_TO_STEP_MS * `HPW_CLK_KHZ)
`define HPW_SAMPLE_KHZ 8
`define HPW_SAMPLE_CYC (`HPW_CLK_KHZ / `HPW_SAMPLE_KHZ)
`define HPW_FIFO_DEPTH 100
`define HPW_FIFO_LAST 7'h63
`define HPW_MID_SCALE 8'h00
`define HPW_OFS_CTRL 12'h000
`define HPW_OFS_FIFO 12'h004
`define HPW_OFS_STATUS 12'h008
`define HPW_CTRL_STANDBY 0
`define HPW_CTRL_FORCE 1
`define HPW_CTRL_GO 2
`define HPW_CTRL_RST 3
`define HPW_CTRL_TO 4
`define HPW_CTRL_MODE 6
`define HPW_ST_FULL 0
`define HPW_ST_EMPTY 1
`define HPW_ST_UP 2
`define HPW_ST_ON 3
`define HPW_ST_NAK 4
`define HPW_ST_STATE 8
`define HPW_ST_DAC 16
`endif

// ### rtl/hpw_pkg.sv
`include "hpw_params.svh"
package hpw_pkg;
    typedef enum logic [2:0] {
        ST_STANDBY, ST_IDLE, ST_WAKE, ST_PLAY, ST_HOLD, ST_RAMP
    } hpw_state_t;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } hpw_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } hpw_apb_rsp_t;
    typedef struct packed {
        hpw_state_t   st;
        logic         standby;
        logic         force_on;
        logic         go;
        logic [1:0]   to_sel;
        logic [1:0]   mode;
        logic         nak;
        logic         stage_up;
        logic [23:0]  warm_cnt;
        logic [23:0]  tick_cnt;
        logic [23:0]  idle_cnt;
        logic [7:0]   dac;
        logic         boost_en;
        logic         amp_en;
        logic         start;
        hpw_apb_rsp_t rsp;
    } hpw_core_t;
    typedef struct packed {
        logic [`HPW_FIFO_DEPTH-1:0][7:0] mem;
        logic [6:0]                      wr;
        logic [6:0]                      rd;
        logic [6:0]                      cnt;
    } hpw_fifo_t;
endpackage

// ### rtl/hpw_fifo.sv
// Purpose: sample fifo between the register port and the dac
// Assumes: push and pop come from the same clock
// Notes: push when full and pop when empty are ignored
`timescale 1ns/10ps
`include "hpw_params.svh"
module hpw_fifo (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       flush,
    input  wire logic       push,
    input  wire logic [7:0] wdata,
    input  wire logic       pop,
    output logic      [7:0] rdata,
    output logic            full,
    output logic            empty
);
    import hpw_pkg::*;
    hpw_fifo_t r;
    hpw_fifo_t n;
    logic      do_push;
    logic      do_pop;
    assign full  = (r.cnt == 7'(`HPW_FIFO_DEPTH));
    assign empty = (r.cnt == 7'h00);
    assign rdata = r.mem[r.rd];
    always_comb begin
        n = r;
        do_push = push & ~full;
        do_pop  = pop & ~empty;
        if (do_push) begin
            n.mem[r.wr] = wdata;
            n.wr = (r.wr == `HPW_FIFO_LAST) ? 7'h00 : r.wr + 7'h01;
        end
        if (do_pop) begin
            n.rd = (r.rd == `HPW_FIFO_LAST) ? 7'h00 : r.rd + 7'h01;
        end
        if (do_push & ~do_pop) begin
            n.cnt = r.cnt + 7'h01;
        end else if (do_pop & ~do_push) begin
            n.cnt = r.cnt - 7'h01;
        end
        if (flush) begin
            n.wr  = 7'h00;
            n.rd  = 7'h00;
            n.cnt = 7'h00;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule

// ### rtl/hpw_ramp.sv
// Purpose: one ramp step of a twos complement code toward mid-scale
// Assumes: called once per sample tick
// Notes: mid-scale stays put
`timescale 1ns/10ps
`include "hpw_params.svh"
module hpw_ramp (
    input  wire logic [7:0] code,
    output logic      [7:0] step
);
    always_comb begin
        step = code;
        if (code[7]) begin
            step = code + 8'h01;
        end else if (code != `HPW_MID_SCALE) begin
            step = code - 8'h01;
        end
    end
endmodule

// ### bench/hpw_wake_props.sv
// Purpose: port checks of the wake control block
// Assumes: sample period of at least four clocks
// Notes: attached by bind at the foot of this file
`timescale 1ns/10ps
module hpw_wake_props #(
    parameter int STARTUP_CYC = 20
) (
    input wire logic                  core_clk,
    input wire logic                  rst,
    input wire hpw_pkg::hpw_apb_req_t apb_req,
    input wire hpw_pkg::hpw_apb_rsp_t apb_rsp,
    input wire logic                  boost_en,
    input wire logic                  amp_en,
    input wire logic [7:0]            dac_code,
    input wire logic                  playback_start,
    input wire logic [1:0]            playback_mode
);
    import hpw_pkg::*;
    // ****************************************
    // cycles with the output stage enabled
    // ****************************************
    logic [15:0] on_cnt;
    always_ff @(posedge core_clk) begin
        if (rst || !boost_en)
            on_cnt <= 16'h0;
        else if (on_cnt != 16'hffff)
            on_cnt <= on_cnt + 16'h1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_amp_tracks_boost: assert property (amp_en == boost_en)
        else $error("amp enable differs from boost enable");
    a_dac_mid_wake: assert property ($rose(boost_en) |->
        (dac_code == 8'h00) [*8]) else $error("dac moved during wake");
    a_first_sample_late: assert property (
        $changed(dac_code) && boost_en |-> on_cnt >= STARTUP_CYC)
        else $error("sample before start-up ended");
    a_sample_spacing: assert property ($changed(dac_code) |=>
        $stable(dac_code) [*3]) else $error("dac samples too close");
    a_start_needs_up: assert property (playback_start |->
        boost_en && $past(boost_en)) else $error("start with stage off");
    a_start_pulse: assert property (playback_start |=> !playback_start)
        else $error("start longer than one cycle");
    a_ready_wait: assert property ($rose(apb_req.penable) && apb_req.psel
        |=> apb_rsp.pready) else $error("pready not after one wait");
    a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready held");
    a_ready_access: assert property (apb_rsp.pready |->
        apb_req.psel && apb_req.penable) else $error("pready outside access");
    a_unmapped_err: assert property (apb_rsp.pready && !(apb_req.paddr
        inside {12'h000, 12'h004, 12'h008}) |-> apb_rsp.pslverr &&
        apb_rsp.prdata == 32'h0) else $error("unmapped access not refused");
    c_wake: cover property ($rose(boost_en));
    c_start: cover property (playback_start && playback_mode == 2'h1);
    c_err: cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule
bind hpw_wake_ctrl hpw_wake_props #(.STARTUP_CYC(STARTUP_CYC)) props_u (
    .core_clk(core_clk), .rst(rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .boost_en(boost_en), .amp_en(amp_en),
    .dac_code(dac_code), .playback_start(playback_start),
    .playback_mode(playback_mode));

// ### bench/hpw_host.sv
// Purpose: apb host model for the wake control block
// Assumes: pready sampled at rising edges of core_clk
// Notes: idle bus shows inverted last address and data
`timescale 1ns/10ps
module hpw_host (
    input  wire logic                  core_clk,
    output hpw_pkg::hpw_apb_req_t      apb_req,
    input  wire hpw_pkg::hpw_apb_rsp_t apb_rsp
);
    import hpw_pkg::*;
    initial apb_req = '0;
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        int i;
        @(posedge core_clk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge core_clk);
            if (apb_rsp.pready === 1'b1) break;
        end
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '{1'b0, 1'b0, w, ~a, ~d};
        if (i == 40) tb.tmo();
    endtask
endmodule

// ### bench/tb.sv
// Purpose: self-checking bench of the wake control block
// Assumes: shortened start-up, timeout step and sample period
// Notes: stimulus only through the apb host model
`timescale 1ns/10ps
module tb;
    import hpw_pkg::*;
    localparam int SU = 20;
    localparam int TO = 40;
    localparam int SC = 4;
    logic         core_clk;
    logic         rst;
    hpw_apb_req_t apb_req;
    hpw_apb_rsp_t apb_rsp;
    logic         boost_en;
    logic         amp_en;
    logic [7:0]   dac_code;
    logic         playback_start;
    logic [1:0]   playback_mode;
    logic [31:0]  q;
    logic         e;
    int           err_total;
    int           n_compared;
    int           n;
    hpw_wake_ctrl #(.STARTUP_CYC(SU), .TO_STEP_CYC(TO), .SAMPLE_CYC(SC))
    dut_u (.core_clk(core_clk), .rst(rst), .apb_req(apb_req),
           .apb_rsp(apb_rsp), .boost_en(boost_en), .amp_en(amp_en),
           .dac_code(dac_code), .playback_start(playback_start),
           .playback_mode(playback_mode));
    hpw_host host_u (.core_clk(core_clk), .apb_req(apb_req),
                     .apb_rsp(apb_rsp));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic tmo;
        err_total++;
        $display("Error wait: expected event, seen none");
        wrap_up();
    endtask
    task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            err_total++;
            $display("Error %s: expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        logic [31:0] r;
        logic        f;
        host_u.xfer(1'b1, a, d, r, f);
    endtask
    task automatic rd(logic [11:0] a);
        host_u.xfer(1'b0, a, 32'h0, q, e);
    endtask
    task automatic wdac;
        logic [7:0] v;
        v = dac_code;
        n = 0;
        while (dac_code === v) begin
            @(posedge core_clk);
            n++;
            if (n > 3000) tmo();
        end
    endtask
    task automatic wstart;
        n = 0;
        while (playback_start !== 1'b1) begin
            @(posedge core_clk);
            n++;
            if (n > 500) tmo();
        end
    endtask
    task automatic wboost(logic v);
        n = 0;
        while (boost_en !== v) begin
            @(posedge core_clk);
            n++;
            if (n > 3000) tmo();
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        err_total = 0;
        n_compared = 0;
        rst = 1'b1;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rd(12'h000);
        chk("ctrl", 32'h1, q);
        rd(12'h008);
        chk("state", 32'h0, q[10:8]);
        rd(12'h00c);
        chk("slverr", 32'h1, e);
        chk("rdata", 32'h0, q);
        wr(12'h004, 32'h33);
        rd(12'h008);
        chk("empty", 32'h1, q[1]);
        chk("boost", 32'h0, boost_en);
        wr(12'h000, 32'h0);
        rd(12'h008);
        chk("state", 32'h1, q[10:8]);
        $display("test standby done");
        for (int s = 0; s < 4; s++) begin
            wr(12'h000, 32'(s) << 4);
            wr(12'h004, 32'hf8);
            wboost(1'b1);
            wdac();
            chk("wake", 32'h1, n >= SU && n <= SU + 6);
            chk("first", 32'hf8, dac_code);
            wdac();
            chk("hold", 32'h1, n - (s + 1) * TO inside {[0:12]});
            chk("ramp", 32'hf9, dac_code);
            wr(12'h004, 32'h55);
            rd(12'h008);
            chk("discard", 32'h1, q[1]);
            wboost(1'b0);
            chk("dac", 32'h0, dac_code);
            rd(12'h008);
            chk("state", 32'h1, q[10:8]);
            chk("enable", 32'h0, amp_en);
        end
        $display("test fifo playback done");
        wr(12'h000, 32'h2);
        wboost(1'b1);
        chk("force", 32'h1, n <= 4);
        repeat (SU + 4) @(posedge core_clk);
        wr(12'h004, 32'h01);
        wdac();
        chk("nodelay", 32'h1, n <= SC + 4);
        wdac();
        repeat (20) @(posedge core_clk);
        chk("held", 32'h1, boost_en);
        wr(12'h000, 32'h0);
        wboost(1'b0);
        chk("release", 32'h1, n <= 8);
        $display("test force on done");
        wr(12'h000, 32'h44);
        wstart();
        chk("start", 32'h1, n >= SU);
        chk("up", 32'h1, boost_en);
        chk("mode", 32'h1, playback_mode);
        wr(12'h000, 32'h84);
        wstart();
        chk("hold go", 32'h1, n <= 4);
        chk("mode", 32'h2, playback_mode);
        wr(12'h000, 32'h8);
        rd(12'h000);
        chk("ctrl", 32'h1, q);
        chk("boost", 32'h0, boost_en);
        $display("test go and soft reset done");
        wrap_up();
    end
endmodule
